// *** logic/sser_pkg.sv ***
// Constants shared by the status and event reporting block.
package sser_pkg;
    // Width of every status register.
    localparam int REG_W = 16;

    // Command codes presented on the command port.
    localparam logic [3:0] CMD_OPER_COND = 4'h0;
    localparam logic [3:0] CMD_OPER_ENAB = 4'h1;
    localparam logic [3:0] CMD_OPER_ENRD = 4'h2;
    localparam logic [3:0] CMD_OPER_EVEN = 4'h3;
    localparam logic [3:0] CMD_PRESET    = 4'h4;
    localparam logic [3:0] CMD_QUES_COND = 4'h5;
    localparam logic [3:0] CMD_QUES_ENAB = 4'h6;
    localparam logic [3:0] CMD_QUES_ENRD = 4'h7;
    localparam logic [3:0] CMD_QUES_EVEN = 4'h8;

    // Operation register bit positions.
    localparam int OP_SETTLING   = 1;
    localparam int OP_TRIG_WAIT  = 5;
    localparam int OP_TRAN_ARMED = 6;
    localparam int OP_CONST_VOLT = 8;
    localparam int OP_TRAN_DONE  = 9;
    localparam int OP_CONST_CURR = 10;
    localparam int OP_SAMPLE     = 11;
    localparam int OP_LIST_DONE  = 12;
    localparam int OP_LIST_RUN   = 14;

    // Questionable register bit positions.
    localparam int QU_VMODE_ERR  = 0;
    localparam int QU_CMODE_ERR  = 1;
    localparam int QU_BIT3       = 3;
    localparam int QU_BIT6       = 6;
    localparam int QU_VOLT_ERR   = 12;
    localparam int QU_CURR_ERR   = 13;
    localparam int QU_SINK       = 14;

    // Bits that carry a condition; all others read as zero.
    localparam logic [15:0] OPER_USED_MASK = 16'h5F62;
    localparam logic [15:0] QUES_USED_MASK = 16'h704B;
    // Only these questionable bits are latched as events.
    localparam logic [15:0] QUES_LATCH_MASK = 16'h3000;

    // Reset and preset values of the enable masks.
    localparam logic [15:0] OPER_ENAB_RST = 16'h0000;
    localparam logic [15:0] QUES_ENAB_RST = 16'h0000;
    localparam logic [15:0] OPER_PRESET   = 16'h2001;
    localparam logic [15:0] QUES_PRESET   = 16'h00FF;

    // Summary bit positions in the status byte.
    localparam int STB_QUES_BIT = 3;
    localparam int STB_OPER_BIT = 7;
endpackage

// *** logic/sser_top.sv ***
// Status condition, event and enable registers with status byte summaries.
// Notes on behaviour
// - Operation condition follows live state, unlatched.
// - Constant voltage bit 8, constant current 10.
// - Trigger wait 5, armed 6, transient done 9.
// - Sample 11, settling 1, list 12/14; rest zero.
// - Status bit 7 ORs enabled operation events.
// - Operation enable mask written and read back.
// - Operation events stay latched until read.
// - Reading operation events returns then clears them.
// - Preset loads enables 8193 and 255.
// - Only questionable bits 13, 12 are latched.
// - Questionable bits 0, 1 never latched.
// - Reading questionable events returns then clears them.
// - Questionable condition shows live state.
// - Questionable bits 0 and 1 may coexist.
// - Questionable bit map 0,1,3,6,12,13,14.
// - Status bit 3 ORs enabled questionable events.
`timescale 1ns/1ps
`default_nettype none
module sser_top (
    input  wire logic        REF_CLK,                 // Device clock, 40 MHz.
    input  wire logic        NRST,                    // Async reset, low.
    input  wire logic        CMD_VALID,               // Command strobe.
    input  wire logic [3:0]  CMD_CODE,                // Command code.
    input  wire logic [15:0] CMD_DATA,                // Write value.
    input  wire logic        SETTLING_FLAG,           // Output settling.
    input  wire logic        TRIGGER_WAIT_FLAG,       // Waiting for trigger.
    input  wire logic        TRANSIENT_ARMED_FLAG,    // Transient armed.
    input  wire logic        CONST_VOLT_FLAG,         // Constant voltage.
    input  wire logic        TRANSIENT_DONE_FLAG,     // Transient complete.
    input  wire logic        CONST_CURR_FLAG,         // Constant current.
    input  wire logic        SAMPLE_DONE_FLAG,        // Sample complete.
    input  wire logic        LIST_DONE_FLAG,          // List complete.
    input  wire logic        LIST_RUNNING_FLAG,       // List running.
    input  wire logic        VOLTAGE_MODE_ERROR_FLAG, // Voltage mode error.
    input  wire logic        CURRENT_MODE_ERROR_FLAG, // Current mode error.
    input  wire logic        QUESTIONABLE_BIT3_FLAG,  // Extra error flag.
    input  wire logic        QUESTIONABLE_BIT6_FLAG,  // Extra error flag.
    input  wire logic        VOLTAGE_ERROR_FLAG,      // Voltage error.
    input  wire logic        CURRENT_ERROR_FLAG,      // Current error.
    input  wire logic        SINK_FLAG,               // Sinking power.
    output logic             RESP_VALID,              // Query answer strobe.
    output logic      [15:0] RESP_DATA,               // Query answer value.
    output logic      [7:0]  STATUS_BYTE              // Summary bits 7 and 3.
);

    // Rising edges of a condition, limited to the bits that may latch.
    function automatic logic [15:0] rise_of(input logic [15:0] cur,
                                            input logic [15:0] prev,
                                            input logic [15:0] keep);
        rise_of = cur & ~prev & keep;
    endfunction

    logic [15:0] oper_raw;      // Operation flags placed at their bits.
    logic [15:0] ques_raw;      // Questionable flags placed at their bits.
    logic [15:0] oper_s1_r;     // First synchroniser stage.
    logic [15:0] oper_s2_r;     // Second synchroniser stage.
    logic [15:0] ques_s1_r;     // First synchroniser stage.
    logic [15:0] ques_s2_r;     // Second synchroniser stage.
    logic [15:0] oper_cond_r;   // Operation condition register.
    logic [15:0] ques_cond_r;   // Questionable condition register.
    logic [15:0] oper_en_r;     // Operation enable mask.
    logic [15:0] ques_en_r;     // Questionable enable mask.
    logic [15:0] oper_ev_r;     // Operation event latch.
    logic [15:0] ques_ev_r;     // Questionable event latch.
    logic [15:0] oper_en_nxt;   // Next operation enable mask.
    logic [15:0] ques_en_nxt;   // Next questionable enable mask.
    logic [15:0] oper_ev_nxt;   // Next operation event latch.
    logic [15:0] ques_ev_nxt;   // Next questionable event latch.
    logic [15:0] oper_rise;     // New operation events this cycle.
    logic [15:0] ques_rise;     // New questionable events this cycle.
    logic [15:0] resp_nxt;      // Answer value for the present query.
    logic        resp_valid_nxt; // Present command is a query.
    logic [7:0]  stb_nxt;       // Next status byte.
    logic        cmd_oper_rd;   // Clearing read of operation events.
    logic        cmd_ques_rd;   // Clearing read of questionable events.
    logic        cmd_preset;    // Status preset command.
    logic        cmd_oper_wr;   // Operation enable write.
    logic        cmd_ques_wr;   // Questionable enable write.

    // Flags mapped onto their register bits; unused bits are tied low.
    assign oper_raw = {1'h0, LIST_RUNNING_FLAG, 1'h0,
                       LIST_DONE_FLAG, SAMPLE_DONE_FLAG,
                       CONST_CURR_FLAG, TRANSIENT_DONE_FLAG,
                       CONST_VOLT_FLAG, 1'h0,
                       TRANSIENT_ARMED_FLAG, TRIGGER_WAIT_FLAG,
                       3'h0, SETTLING_FLAG, 1'h0};
    // Bits 0 and 1 may both be high while the output settles.
    assign ques_raw = {1'h0, SINK_FLAG, CURRENT_ERROR_FLAG,
                       VOLTAGE_ERROR_FLAG, 5'h00,
                       QUESTIONABLE_BIT6_FLAG, 2'h0,
                       QUESTIONABLE_BIT3_FLAG, 1'h0,
                       CURRENT_MODE_ERROR_FLAG,
                       VOLTAGE_MODE_ERROR_FLAG};

    // Command decode.
    assign cmd_oper_rd = CMD_VALID && (CMD_CODE == sser_pkg::CMD_OPER_EVEN);
    assign cmd_ques_rd = CMD_VALID && (CMD_CODE == sser_pkg::CMD_QUES_EVEN);
    assign cmd_preset  = CMD_VALID && (CMD_CODE == sser_pkg::CMD_PRESET);
    assign cmd_oper_wr = CMD_VALID && (CMD_CODE == sser_pkg::CMD_OPER_ENAB);
    assign cmd_ques_wr = CMD_VALID && (CMD_CODE == sser_pkg::CMD_QUES_ENAB);

    // New events are the rising edges of the synchronised conditions.
    // The condition register serves as the previous value, so an event
    // and its condition bit become visible on the same edge.
    assign oper_rise = rise_of(oper_s2_r, oper_cond_r,
                               sser_pkg::OPER_USED_MASK);
    // Bits 0 and 1 are not in the latch mask, so they never latch.
    assign ques_rise = rise_of(ques_s2_r, ques_cond_r,
                               sser_pkg::QUES_LATCH_MASK);

    // A clearing read empties the latch, but an event of the same cycle
    // is ORed in afterwards so it is reported on the next read.
    assign oper_ev_nxt = (cmd_oper_rd ? 16'h0000 : oper_ev_r)
                         | oper_rise;
    assign ques_ev_nxt = (cmd_ques_rd ? 16'h0000 : ques_ev_r)
                         | ques_rise;

    // Enable masks: preset is tested first; the two never coincide.
    assign oper_en_nxt = cmd_preset  ? sser_pkg::OPER_PRESET :
                         cmd_oper_wr ? CMD_DATA : oper_en_r;
    assign ques_en_nxt = cmd_preset  ? sser_pkg::QUES_PRESET :
                         cmd_ques_wr ? CMD_DATA : ques_en_r;

    // Summaries are built from the next values so that the byte and the
    // registers it summarises always change on the same edge.
    always_comb begin
        stb_nxt = 8'h00;
        stb_nxt[sser_pkg::STB_OPER_BIT] = |(oper_ev_nxt & oper_en_nxt);
        stb_nxt[sser_pkg::STB_QUES_BIT] = |(ques_ev_nxt & ques_en_nxt);
    end

    // Query answer selection; the event reads return the value before
    // the clear.
    always_comb begin
        resp_valid_nxt = CMD_VALID;
        case (CMD_CODE)
            sser_pkg::CMD_OPER_COND: resp_nxt = oper_cond_r;
            sser_pkg::CMD_OPER_ENRD: resp_nxt = oper_en_r;
            sser_pkg::CMD_OPER_EVEN: resp_nxt = oper_ev_r;
            sser_pkg::CMD_QUES_COND: resp_nxt = ques_cond_r;
            sser_pkg::CMD_QUES_ENRD: resp_nxt = ques_en_r;
            sser_pkg::CMD_QUES_EVEN: resp_nxt = ques_ev_r;
            default: begin
                // Writes and preset give no answer.
                resp_nxt = 16'h0000;
                resp_valid_nxt = 1'h0;
            end
        endcase
    end

    // Condition inputs are asynchronous pins, so two stages precede use.
    // Only the second stage is read, as the first may still be settling.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            oper_s1_r <= 16'h0000;
            oper_s2_r <= 16'h0000;
            ques_s1_r <= 16'h0000;
            ques_s2_r <= 16'h0000;
        end else begin
            oper_s1_r <= oper_raw;
            oper_s2_r <= oper_s1_r;
            ques_s1_r <= ques_raw;
            ques_s2_r <= ques_s1_r;
        end
    end

    // Condition registers track live state with no latching.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            oper_cond_r <= 16'h0000;
            ques_cond_r <= 16'h0000;
        end else begin
            oper_cond_r <= oper_s2_r & sser_pkg::OPER_USED_MASK;
            ques_cond_r <= ques_s2_r & sser_pkg::QUES_USED_MASK;
        end
    end

    // Enable masks and event latches.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            oper_en_r <= sser_pkg::OPER_ENAB_RST;
            ques_en_r <= sser_pkg::QUES_ENAB_RST;
            oper_ev_r <= 16'h0000;
            ques_ev_r <= 16'h0000;
        end else begin
            oper_en_r <= oper_en_nxt;
            ques_en_r <= ques_en_nxt;
            oper_ev_r <= oper_ev_nxt;
            ques_ev_r <= ques_ev_nxt;
        end
    end

    // Output registers: answers appear one edge after the command.
    // The answer value is kept between commands, so a host that is slow
    // to look still finds it after the one-cycle strobe has gone.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            RESP_VALID  <= 1'h0;
            RESP_DATA   <= 16'h0000;
            STATUS_BYTE <= 8'h00;
        end else begin
            RESP_VALID  <= resp_valid_nxt;
            STATUS_BYTE <= stb_nxt;
            if (CMD_VALID) begin
                RESP_DATA <= resp_nxt;
            end
        end
    end

    // Checks on the block's own registers.
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);

    // A mask write, and a query of that mask, for each group.
    sequence oper_wr_s;
        cmd_oper_wr;
    endsequence
    sequence oper_enrd_s;
        CMD_VALID && (CMD_CODE == sser_pkg::CMD_OPER_ENRD);
    endsequence
    sequence ques_wr_s;
        cmd_ques_wr;
    endsequence
    sequence ques_enrd_s;
        CMD_VALID && (CMD_CODE == sser_pkg::CMD_QUES_ENRD);
    endsequence

    // Condition output equals the pin state three edges earlier.
    oper_live_a: assert property (
        oper_cond_r == ($past(oper_raw, 3) & sser_pkg::OPER_USED_MASK))
        else $error("operation condition does not follow its inputs");

    // Unused operation bits never appear in the condition or event registers.
    oper_unused_a: assert property (
        ((oper_cond_r | oper_ev_r) & ~sser_pkg::OPER_USED_MASK) == 16'h0000)
        else $error("unused operation bit is set");

    // The operation summary tracks the enabled events.
    oper_summary_a: assert property (
        STATUS_BYTE[sser_pkg::STB_OPER_BIT] == |(oper_ev_r & oper_en_r))
        else $error("operation summary bit is wrong");

    // A write lands in the mask whole, all sixteen bits.
    oper_mask_a: assert property (
        oper_wr_s |=> (oper_en_r == $past(CMD_DATA)))
        else $error("operation mask write did not land");

    // A query of the mask answers with the value it held.
    oper_rdback_a: assert property (
        oper_enrd_s |=> RESP_VALID && (RESP_DATA == $past(oper_en_r)))
        else $error("operation mask read-back differs");

    // A latched event stays until a clearing read.
    oper_hold_a: assert property (
        !cmd_oper_rd |=> (oper_ev_r & $past(oper_ev_r)) == $past(oper_ev_r))
        else $error("operation event lost without a read");

    // A new rising condition is caught in the latch at once.
    oper_set_a: assert property (
        (oper_rise != 16'h0000) |=>
        (oper_ev_r & $past(oper_rise)) == $past(oper_rise))
        else $error("operation event was not latched");

    // The read returns the latched value and the latch empties.
    oper_read_a: assert property (
        cmd_oper_rd && (oper_rise == 16'h0000) |=>
        RESP_VALID && (RESP_DATA == $past(oper_ev_r))
        && (oper_ev_r == 16'h0000))
        else $error("operation event read did not return and clear");

    // Preset loads both masks.
    preset_load_a: assert property (
        cmd_preset |=> (oper_en_r == sser_pkg::OPER_PRESET)
        && (ques_en_r == sser_pkg::QUES_PRESET))
        else $error("preset did not load the masks");

    // Writes and preset are never answered.
    resp_quiet_a: assert property (
        (cmd_preset || cmd_oper_wr || cmd_ques_wr) |=> !RESP_VALID)
        else $error("a write or preset was answered");

    // Only the voltage and current error bits latch in the questionable event register.
    ques_latch_a: assert property (
        (ques_ev_r & ~sser_pkg::QUES_LATCH_MASK) == 16'h0000)
        else $error("questionable event latched an illegal bit");

    // Mode error bits follow the live state and never latch.
    ques_mode_a: assert property (
        !ques_ev_r[sser_pkg::QU_VMODE_ERR]
        && !ques_ev_r[sser_pkg::QU_CMODE_ERR])
        else $error("questionable mode error bit latched");

    // A voltage or current error that rises is caught in the latch.
    ques_set_a: assert property (
        (ques_rise != 16'h0000) |=>
        (ques_ev_r & $past(ques_rise)) == $past(ques_rise))
        else $error("questionable event was not latched");

    // A latched error stays until the questionable read.
    ques_hold_a: assert property (
        !cmd_ques_rd |=> (ques_ev_r & $past(ques_ev_r)) == $past(ques_ev_r))
        else $error("questionable event lost without a read");

    // The questionable read returns and clears.
    ques_read_a: assert property (
        cmd_ques_rd && (ques_rise == 16'h0000) |=>
        RESP_VALID && (RESP_DATA == $past(ques_ev_r))
        && (ques_ev_r == 16'h0000))
        else $error("questionable event read did not return and clear");

    // The questionable summary tracks the enabled events.
    ques_summary_a: assert property (
        STATUS_BYTE[sser_pkg::STB_QUES_BIT] == |(ques_ev_r & ques_en_r))
        else $error("questionable summary bit is wrong");

    // An event arriving during a clearing read survives it.
    event_kept_a: assert property (
        cmd_oper_rd |=> (oper_ev_r & $past(oper_rise)) == $past(oper_rise))
        else $error("event lost during a clearing read");

    // The same holds for the questionable latch.
    ques_kept_a: assert property (
        cmd_ques_rd |=> (ques_ev_r & $past(ques_rise)) == $past(ques_rise))
        else $error("questionable event lost during a clearing read");

    // Questionable condition equals the pin state three edges earlier;
    // both mode error bits may stand together while the output settles.
    ques_live_a: assert property (
        ques_cond_r == ($past(ques_raw, 3) & sser_pkg::QUES_USED_MASK))
        else $error("questionable condition does not follow its inputs");

    // A questionable mask write lands whole.
    ques_mask_a: assert property (
        ques_wr_s |=> (ques_en_r == $past(CMD_DATA)))
        else $error("questionable mask write did not land");

    // A query of the questionable mask answers with its value.
    ques_rdback_a: assert property (
        ques_enrd_s |=> RESP_VALID && (RESP_DATA == $past(ques_en_r)))
        else $error("questionable mask read-back differs");

    // The answer value stands until the next command.
    resp_hold_a: assert property (
        !CMD_VALID |=> $stable(RESP_DATA))
        else $error("answer value changed without a command");

endmodule
`default_nettype wire

// *** tb/sser_host.sv ***
// Host model that issues status commands and collects the answers.
`timescale 1ns/1ps
`default_nettype none
module sser_host (
    input  wire logic        clk,        // Device clock.
    input  wire logic        resp_valid, // Answer strobe from the device.
    input  wire logic [15:0] resp_data,  // Answer value from the device.
    output logic             cmd_valid,  // Command strobe.
    output logic      [3:0]  cmd_code,   // Command code.
    output logic      [15:0] cmd_data    // Command write value.
);
    // Nothing is requested before the first transfer is asked for.
    initial begin
        cmd_valid = 1'h0;
        cmd_code  = 4'h0;
        cmd_data  = 16'h0000;
    end

    // One command: driven at a falling edge, taken at the next rising edge.
    // The answer strobe stands for one cycle, so it is read at the falling
    // edge after the taking edge, when the registered outputs have settled.
    task automatic xfer(input  logic [3:0]  code,
                        input  logic [15:0] data,
                        output logic        got,
                        output logic [15:0] val);
        @(negedge clk);
        cmd_valid = 1'h1;
        cmd_code  = code;
        cmd_data  = data;
        @(posedge clk);
        @(negedge clk);
        got       = resp_valid;
        val       = resp_data;
        cmd_valid = 1'h0;
        cmd_code  = ~code;
        cmd_data  = ~data;
    endtask
endmodule
`default_nettype wire

// *** tb/test_status_event_reporting.sv ***
// Self-checking testbench for the status and event reporting block.
`timescale 1ns/1ps
`default_nettype none
module test_status_event_reporting;
    logic        ref_clk     = 1'h0;     // Device clock, 40 MHz.
    logic        nrst        = 1'h0;     // Reset, active low.
    logic [15:0] op_f        = 16'h0000; // Operation flag levels by bit.
    logic [15:0] qu_f        = 16'h0000; // Questionable flag levels by bit.
    logic        cmd_valid;              // Command strobe from the host.
    logic [3:0]  cmd_code;               // Command code from the host.
    logic [15:0] cmd_data;               // Write value from the host.
    logic        resp_valid;             // Answer strobe.
    logic [15:0] resp_data;              // Answer value.
    logic [7:0]  status_byte;            // Summary byte.
    int          failures    = 0;        // Mismatches seen.
    int          comparisons = 0;        // Comparisons made.
    int          cycles      = 0;        // Clock cycles run.

    // Half period of 12.5 ns gives 40 MHz.
    always #12.5 ref_clk = ~ref_clk;

    // The run needs a few hundred cycles, so this limit only catches hangs.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            print_verdict();
        end
    end

    sser_top i_sser_top (.REF_CLK(ref_clk), .NRST(nrst),
        .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code), .CMD_DATA(cmd_data),
        .SETTLING_FLAG(op_f[1]), .TRIGGER_WAIT_FLAG(op_f[5]),
        .TRANSIENT_ARMED_FLAG(op_f[6]), .CONST_VOLT_FLAG(op_f[8]),
        .TRANSIENT_DONE_FLAG(op_f[9]), .CONST_CURR_FLAG(op_f[10]),
        .SAMPLE_DONE_FLAG(op_f[11]), .LIST_DONE_FLAG(op_f[12]),
        .LIST_RUNNING_FLAG(op_f[14]), .VOLTAGE_MODE_ERROR_FLAG(qu_f[0]),
        .CURRENT_MODE_ERROR_FLAG(qu_f[1]), .QUESTIONABLE_BIT3_FLAG(qu_f[3]),
        .QUESTIONABLE_BIT6_FLAG(qu_f[6]), .VOLTAGE_ERROR_FLAG(qu_f[12]),
        .CURRENT_ERROR_FLAG(qu_f[13]), .SINK_FLAG(qu_f[14]),
        .RESP_VALID(resp_valid), .RESP_DATA(resp_data),
        .STATUS_BYTE(status_byte));

    sser_host i_sser_host (.clk(ref_clk), .resp_valid(resp_valid),
        .resp_data(resp_data), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_data(cmd_data));

    // Compares a seen value with an expected one; unknowns never match.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Query that must be answered with the given value.
    task automatic q(input logic [3:0] code, input logic [15:0] exp);
        logic        got;
        logic [15:0] val;
        i_sser_host.xfer(code, 16'h0000, got, val);
        check({15'h0000, got}, 16'h0001);
        check(val, exp);
    endtask

    // Write or ignored code: no answer strobe may appear.
    task automatic w(input logic [3:0] code, input logic [15:0] data);
        logic        got;
        logic [15:0] val;
        i_sser_host.xfer(code, data, got, val);
        check({15'h0000, got}, 16'h0000);
    endtask

    // Flags need three edges to reach the registers; four give margin.
    task automatic settle();
        repeat (4) @(negedge ref_clk);
    endtask

    // Summary byte compare.
    task automatic sb(input logic [7:0] exp);
        check({8'h00, status_byte}, {8'h00, exp});
    endtask

    // Everything reads zero after reset.
    task automatic t_reset();
        logic [3:0] codes [6];
        codes = '{sser_pkg::CMD_OPER_COND, sser_pkg::CMD_OPER_ENRD,
                  sser_pkg::CMD_OPER_EVEN, sser_pkg::CMD_QUES_COND,
                  sser_pkg::CMD_QUES_ENRD, sser_pkg::CMD_QUES_EVEN};
        foreach (codes[i]) q(codes[i], 16'h0000);
        sb(8'h00);
        $display("test reset done");
    endtask

    // Each operation flag lands on its own bit, live and latched.
    task automatic t_oper_map();
        int bits [9];
        bits = '{1, 5, 6, 8, 9, 10, 11, 12, 14};
        foreach (bits[i]) begin
            op_f = 16'h0001 << bits[i];
            settle();
            q(sser_pkg::CMD_OPER_COND, 16'h0001 << bits[i]);
            op_f = 16'h0000;
            settle();
            q(sser_pkg::CMD_OPER_COND, 16'h0000);
            q(sser_pkg::CMD_OPER_EVEN, 16'h0001 << bits[i]);
        end
        op_f = 16'hFFFF;
        settle();
        q(sser_pkg::CMD_OPER_COND, 16'h5F62);
        op_f = 16'h0000;
        settle();
        q(sser_pkg::CMD_OPER_EVEN, 16'h5F62);
        $display("test operation map done");
    endtask

    // Mask write and readback, summary bit 7, latch held until read.
    task automatic t_oper_event();
        w(sser_pkg::CMD_OPER_ENAB, 16'h0500);
        q(sser_pkg::CMD_OPER_ENRD, 16'h0500);
        w(sser_pkg::CMD_QUES_ENAB, 16'h2FC4);
        q(sser_pkg::CMD_QUES_ENRD, 16'h2FC4);
        op_f[5] = 1'h1;
        settle();
        sb(8'h00);
        op_f = 16'h0400;
        settle();
        sb(8'h80);
        op_f = 16'h0000;
        settle();
        sb(8'h80);
        q(sser_pkg::CMD_OPER_EVEN, 16'h0420);
        sb(8'h00);
        q(sser_pkg::CMD_OPER_EVEN, 16'h0000);
        $display("test operation event done");
    endtask

    // Questionable map, latching of bits 12 and 13 only, summary bit 3.
    task automatic t_ques();
        w(sser_pkg::CMD_QUES_ENAB, 16'hFFFF);
        qu_f = 16'h0003;
        settle();
        q(sser_pkg::CMD_QUES_COND, 16'h0003);
        sb(8'h00);
        w(sser_pkg::CMD_QUES_ENAB, 16'h1000);
        qu_f = 16'hFFFF;
        settle();
        q(sser_pkg::CMD_QUES_COND, 16'h704B);
        sb(8'h08);
        qu_f = 16'h0000;
        settle();
        q(sser_pkg::CMD_QUES_COND, 16'h0000);
        q(sser_pkg::CMD_QUES_EVEN, 16'h3000);
        sb(8'h00);
        q(sser_pkg::CMD_QUES_EVEN, 16'h0000);
        $display("test questionable done");
    endtask

    // Preset values, and an unknown code that must stay unanswered.
    task automatic t_preset();
        w(sser_pkg::CMD_PRESET, 16'h0000);
        q(sser_pkg::CMD_OPER_ENRD, 16'h2001);
        q(sser_pkg::CMD_QUES_ENRD, 16'h00FF);
        w(4'hF, 16'h1234);
        op_f[10] = 1'h1;
        settle();
        sb(8'h00);
        op_f = 16'h0000;
        q(sser_pkg::CMD_OPER_EVEN, 16'h0400);
        $display("test preset done");
    endtask

    // An event landing on the edge of a clearing read must survive.
    task automatic t_collide();
        logic        got;
        logic [15:0] val;
        w(sser_pkg::CMD_OPER_ENAB, 16'h4000);
        @(negedge ref_clk);
        op_f = 16'h4000;
        @(negedge ref_clk);
        i_sser_host.xfer(sser_pkg::CMD_OPER_EVEN, 16'h0000, got, val);
        check({15'h0000, got}, 16'h0001);
        check(val, 16'h0000);
        sb(8'h80);
        q(sser_pkg::CMD_OPER_EVEN, 16'h4000);
        op_f = 16'h0000;
        $display("test read collision done");
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Reset for two cycles, then the scenarios in turn.
    initial begin
        repeat (2) @(negedge ref_clk);
        nrst = 1'h1;
        t_reset();
        t_oper_map();
        t_oper_event();
        t_ques();
        t_preset();
        t_collide();
        print_verdict();
    end
endmodule
`default_nettype wire
